/* File: core/acs_pkg.sv */
// package of constants for the self-clocked serial result output sequencer
// assumes a 250 MHz core clock; the power-on count derives from the time given here
package acs_pkg;

  // core clock period
  localparam int CLK_PERIOD_NS = 4;

  // power-on hold time after supply crosses its threshold
  localparam int POR_TIME_NS   = 500000;
  // least time, so rounded up to whole cycles
  localparam int POR_CYCLES_DEF = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // default half period of the internal serial clock, in core cycles
  localparam int SCK_HALF_DEF  = 16;

  // output word layout
  localparam int WORD_W        = 32;
  localparam int RES_W         = 31;
  localparam int FLAG_POS      = 31;
  localparam logic [4:0] LAST_BIT = 5'h1F;

  // result buffer depth
  localparam int FIFO_DEPTH    = 8;

  // counter widths
  localparam int POR_CNT_W     = 20;
  localparam int DIV_CNT_W     = 8;

  // sequencer states
  typedef enum logic [2:0] {
    ST_POR,
    ST_EXT,
    ST_CONV,
    ST_SLEEP,
    ST_OUT
  } acs_state_t;

endpackage

/* File: core/acs_fifo.sv */
// small synchronous FIFO carrying conversion results to the output sequencer
// assumes writer and reader share one clock and the same clock enable
`timescale 1ns/1ps
module acs_fifo
  import acs_pkg::*;
#(
  parameter int W = RES_W,
  parameter int D = FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  // filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] wr_ptr_nxt;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [AW:0]   count_r;
  logic [AW:0]   count_nxt;
  logic          ready_r;
  logic          ready_nxt;
  logic          push;
  logic          pop;

  // ready kept as a flop so the ready seen upstream needs no gate after it
  assign in_ready_o  = ready_r;
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem[rd_ptr_r];
  assign push        = in_valid_i & ready_r;
  assign pop         = out_ready_i & out_valid_o;

  // pointer and occupancy update
  always_comb
  begin
    wr_ptr_nxt = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
    rd_ptr_nxt = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
    count_nxt  = count_r;
    if (push && !pop)
      count_nxt = (AW+1)'(count_r + 1'b1);
    else if (pop && !push)
      count_nxt = (AW+1)'(count_r - 1'b1);
    ready_nxt  = (count_nxt != (AW+1)'(D));
  end

  // register stage; storage has no reset, pointers, count and ready do
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b1;
    end
    else if (ce_i)
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      ready_r  <= ready_nxt;
      if (push)
        mem[wr_ptr_r] <= in_data_i;
    end
  end

endmodule

/* File: core/acs_top.sv */
// output sequencer of a delta-sigma converter driving its own serial clock
// assumes the converter core and chip-select comparator sit outside; SCK is
// split into input, output and output enable, SDO into output and enable, pulls resolved by the bench
//
// Summary of operation
// [R1] hold power-on reset about 0.5 ms, then sample SCK to pick clock mode
// [R2] weak SCK pull-up during power-on reset; high selects internal, low external
// [R3] while converting in internal mode, SCK and SDO both stay high
// [R4] conversion done: SCK and SDO go low, device sleeps
// [R5] sleep at least half an SCK period, then start output unprompted
// [R6] output cycle runs from first to the 32nd generated rising SCK edge
// [R7] SDO advances on each own SCK falling edge; generated clock drives SCK pin
// [R8] controller captures SDO on rising SCK; flag first, last bit at 32nd
// [R9] after 32nd rise: SDO high, SCK stays high, new conversion starts
// [R10] in continuous mode the controller ties chip select low, drives nothing
// [R11] autostart: weak chip-select pull-up held while converting
// [R12] autostart: on completion sleep and enable 25 nA chip-select sink
// [R13] chip select below threshold wakes device into 32-edge output cycle
// [R14] autostart: after 32nd rise, pull chip select high, stop sink, convert
// [R15] each threshold crossing re-evaluates mode (code holds internal mode while it drives SCK); SCK pull-up on while discharging
// [R16] controller must not pull SCK low while chip select discharges
// [R17] on falling edge of the done flag, load result into output shift register
// [R18] internal SCK derived from core clock by a divider parameter
// [R19] output word is done flag first, then 31 result bits from the core
`timescale 1ns/1ps
module acs_top
  import acs_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYCLES_DEF,
  parameter int SCK_HALF   = SCK_HALF_DEF
)
(
  // clock, reset, enable
  input  wire logic             CLK_I,
  input  wire logic             RESETN_I,
  input  wire logic             CE_I,
  // serial clock pin
  input  wire logic             SCK_I,
  output logic                  SCK_O,
  output logic                  SCK_OE_O,
  output logic                  SCK_PU_O,
  // serial data pin
  output logic                  SDO_O,
  output logic                  SDO_OE_O,
  // chip-select pin analog controls and comparator
  input  wire logic             CS_BELOW_I,
  output logic                  CS_PU_O,
  output logic                  CS_SINK_O,
  // converter core
  output logic                  CONV_START_O,
  input  wire logic             RES_VALID_I,
  output logic                  RES_READY_O,
  input  wire logic [RES_W-1:0] RES_DATA_I,
  // status
  output logic                  MODE_INT_O
);

  // pin synchronisers
  logic sck_s1_r;
  logic sck_s2_r;
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_d_r;

  // power-on and mode state
  logic [POR_CNT_W-1:0] por_cnt_r;
  logic [POR_CNT_W-1:0] por_cnt_nxt;
  logic                 mode_int_r;
  logic                 mode_int_nxt;

  // sequencer state
  acs_state_t           state_r;
  acs_state_t           state_nxt;
  logic [DIV_CNT_W-1:0] div_cnt_r;
  logic [DIV_CNT_W-1:0] div_cnt_nxt;
  logic                 half_done_r;
  logic                 half_done_nxt;
  logic [4:0]           bit_cnt_r;
  logic [4:0]           bit_cnt_nxt;
  logic [WORD_W-1:0]    shreg_r;
  logic [WORD_W-1:0]    shreg_nxt;
  logic                 sck_r;
  logic                 sck_nxt;
  logic                 sck_oe_r;
  logic                 sck_oe_nxt;
  logic                 sck_pu_r;
  logic                 sck_pu_nxt;
  logic                 sdo_r;
  logic                 sdo_nxt;
  logic                 sdo_oe_r;
  logic                 sdo_oe_nxt;
  logic                 cs_pu_r;
  logic                 cs_pu_nxt;
  logic                 cs_sink_r;
  logic                 cs_sink_nxt;
  logic                 start_r;
  logic                 start_nxt;

  // result buffer interface
  logic                 fifo_valid;
  logic                 fifo_pop;
  logic [RES_W-1:0]     fifo_data;
  logic                 fifo_in_ready;

  // derived events
  logic                 cs_cross;
  logic                 div_tick;
  logic                 por_end;

  // results queue here so the converter can run ahead of a slow output
  acs_fifo #(
    .W (RES_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .resetn_i    (RESETN_I),
    .ce_i        (CE_I),
    .in_valid_i  (RES_VALID_I),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (RES_DATA_I),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // two-flop synchronisers; cs_d_r only ever sees the second stage
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      sck_s1_r <= 1'b1;
      sck_s2_r <= 1'b1;
      cs_s1_r  <= 1'b0;
      cs_s2_r  <= 1'b0;
      cs_d_r   <= 1'b0;
    end
    else if (CE_I)
    begin
      sck_s1_r <= SCK_I;
      sck_s2_r <= sck_s1_r;
      cs_s1_r  <= CS_BELOW_I;
      cs_s2_r  <= cs_s1_r;
      cs_d_r   <= cs_s2_r;
    end
  end

  // either direction of the comparator counts as a crossing
  assign cs_cross = cs_s2_r ^ cs_d_r;
  assign div_tick = (div_cnt_r == DIV_CNT_W'(SCK_HALF - 1)); // R18
  assign por_end  = (por_cnt_r == POR_CNT_W'(POR_CYCLES - 1));

  // power-on counter and clock-mode choice
  always_comb
  begin
    por_cnt_nxt  = por_cnt_r;
    mode_int_nxt = mode_int_r;
    if (state_r == ST_POR)
    begin
      if (!por_end)
        por_cnt_nxt = POR_CNT_W'(por_cnt_r + 1'b1);
      else
        mode_int_nxt = sck_s2_r; // R1 R2
    end
    else if (cs_cross)
    begin
      // while we drive SCK ourselves the pin level is our own, keep internal
      mode_int_nxt = sck_oe_r ? 1'b1 : sck_s2_r; // R15
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      por_cnt_r  <= '0;
      mode_int_r <= 1'b0;
    end
    else if (CE_I)
    begin
      por_cnt_r  <= por_cnt_nxt;
      mode_int_r <= mode_int_nxt;
    end
  end

  // output sequencer
  always_comb
  begin
    state_nxt     = state_r;
    div_cnt_nxt   = div_tick ? '0 : DIV_CNT_W'(div_cnt_r + 1'b1);
    half_done_nxt = half_done_r;
    bit_cnt_nxt   = bit_cnt_r;
    shreg_nxt     = shreg_r;
    sck_nxt       = sck_r;
    sck_oe_nxt    = sck_oe_r;
    sck_pu_nxt    = sck_pu_r;
    sdo_nxt       = sdo_r;
    sdo_oe_nxt    = sdo_oe_r;
    cs_pu_nxt     = cs_pu_r;
    cs_sink_nxt   = cs_sink_r;
    start_nxt     = 1'b0;
    fifo_pop      = 1'b0;
    unique case (state_r)
      ST_POR:
      begin
        sck_pu_nxt = 1'b1; // R2
        sck_oe_nxt = 1'b0;
        sdo_oe_nxt = 1'b0;
        if (por_end)
        begin
          if (sck_s2_r) // R1
          begin
            state_nxt  = ST_CONV;
            start_nxt  = 1'b1;
            sck_nxt    = 1'b1;
            sck_oe_nxt = 1'b1;
            sdo_nxt    = 1'b1;
            sdo_oe_nxt = 1'b1;
            cs_pu_nxt  = 1'b1;
          end
          else
          begin
            state_nxt  = ST_EXT;
            sck_pu_nxt = 1'b0;
          end
        end
      end
      ST_EXT:
      begin
        // external clocking is not served here; wait for a crossing
        if (cs_cross && sck_s2_r) // R15
        begin
          state_nxt  = ST_CONV;
          start_nxt  = 1'b1;
          sck_nxt    = 1'b1;
          sck_oe_nxt = 1'b1;
          sdo_nxt    = 1'b1;
          sdo_oe_nxt = 1'b1;
          cs_pu_nxt  = 1'b1;
        end
      end
      ST_CONV:
      begin
        // flag high on SDO, SCK high, chip select held up
        sck_nxt    = 1'b1; // R3
        sdo_nxt    = 1'b1; // R3
        cs_pu_nxt  = 1'b1; // R11
        if (fifo_valid)
        begin
          fifo_pop      = 1'b1;
          shreg_nxt     = {1'b0, fifo_data}; // R17 R19
          state_nxt     = ST_SLEEP;
          sck_nxt       = 1'b0; // R4
          sdo_nxt       = 1'b0; // R4
          cs_pu_nxt     = 1'b0;
          cs_sink_nxt   = 1'b1; // R12
          sck_pu_nxt    = 1'b1; // R15
          div_cnt_nxt   = '0;
          half_done_nxt = 1'b0;
        end
      end
      ST_SLEEP:
      begin
        if (div_tick)
          half_done_nxt = 1'b1; // R5
        // tied-low chip select reads below at once, so this is the
        // continuous case too; a capacitor delays it in autostart
        if ((half_done_r || div_tick) && cs_s2_r) // R5 R13
        begin
          state_nxt   = ST_OUT;
          div_cnt_nxt = '0;
          bit_cnt_nxt = '0;
        end
      end
      ST_OUT:
      begin
        if (div_tick) // R18
        begin
          if (!sck_r)
            sck_nxt = 1'b1; // R6 R7
          else if (bit_cnt_r == LAST_BIT)
          begin
            // 32nd rise already out: leave SCK high, restart
            state_nxt   = ST_CONV; // R6
            sdo_nxt     = 1'b1; // R9
            start_nxt   = 1'b1; // R9
            cs_pu_nxt   = 1'b1; // R14
            cs_sink_nxt = 1'b0; // R14
            sck_pu_nxt  = 1'b0;
          end
          else
          begin
            sck_nxt     = 1'b0; // R7
            shreg_nxt   = {shreg_r[WORD_W-2:0], 1'b0};
            sdo_nxt     = shreg_r[WORD_W-2]; // R7
            bit_cnt_nxt = 5'(bit_cnt_r + 1'b1);
          end
        end
      end
      default:
      begin
        state_nxt = ST_POR;
      end
    endcase
  end

  // sequencer registers; the 32nd rise is seen one half period after it
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      state_r     <= ST_POR;
      div_cnt_r   <= '0;
      half_done_r <= 1'b0;
      bit_cnt_r   <= '0;
      shreg_r     <= '0;
      sck_r       <= 1'b1;
      sck_oe_r    <= 1'b0;
      sck_pu_r    <= 1'b1;
      sdo_r       <= 1'b1;
      sdo_oe_r    <= 1'b0;
      cs_pu_r     <= 1'b0;
      cs_sink_r   <= 1'b0;
      start_r     <= 1'b0;
    end
    else if (CE_I)
    begin
      state_r     <= state_nxt;
      div_cnt_r   <= div_cnt_nxt;
      half_done_r <= half_done_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      shreg_r     <= shreg_nxt;
      sck_r       <= sck_nxt;
      sck_oe_r    <= sck_oe_nxt;
      sck_pu_r    <= sck_pu_nxt;
      sdo_r       <= sdo_nxt;
      sdo_oe_r    <= sdo_oe_nxt;
      cs_pu_r     <= cs_pu_nxt;
      cs_sink_r   <= cs_sink_nxt;
      start_r     <= start_nxt;
    end
  end

  // ready comes straight from a flop inside the buffer
  assign RES_READY_O  = fifo_in_ready;
  assign SCK_O        = sck_r;
  assign SCK_OE_O     = sck_oe_r; // R7
  assign SCK_PU_O     = sck_pu_r;
  assign SDO_O        = sdo_r;
  assign SDO_OE_O     = sdo_oe_r;
  assign CS_PU_O      = cs_pu_r;
  assign CS_SINK_O    = cs_sink_r;
  assign CONV_START_O = start_r;
  assign MODE_INT_O   = mode_int_r;

endmodule

/* File: sim/acs_top_props.sv */
// checker: serial frame timing and chip-select controls of the sequencer
// assumes it is bound to the sequencer top and sees only its ports
`timescale 1ns/1ps
module acs_top_props
  import acs_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_DEF
)
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // pins and controls
  input wire logic SCK_O,
  input wire logic SDO_O,
  input wire logic CS_BELOW_I,
  input wire logic CS_PU_O,
  input wire logic CS_SINK_O,
  input wire logic CONV_START_O,
  input wire logic MODE_INT_O,
  input wire logic RES_READY_O
);
  logic [15:0] held_r;
  logic [5:0]  rises_r;
  logic        sck_q_r;
  logic        sink_q_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  // cycles SCK held its level; rises since sleep entry
  always_ff @(posedge CLK_I)
  begin
    sck_q_r  <= SCK_O;
    sink_q_r <= CS_SINK_O;
    held_r   <= (SCK_O != sck_q_r) ? 16'h0001 : held_r + 16'h0001;
    if (CS_SINK_O && !sink_q_r)
      rises_r <= 6'h00;
    else if (SCK_O && !sck_q_r)
      rises_r <= rises_r + 6'h01;
  end

  a_conv_lines_high: assert property (MODE_INT_O && CS_PU_O |-> SCK_O && SDO_O)
    else $error("SCK or SDO low while converting");
  a_sleep_entry: assert property ($rose(CS_SINK_O) |-> !SCK_O && !SDO_O && !CS_PU_O)
    else $error("bad line levels at sleep entry");
  a_sdo_on_fall: assert property (CS_SINK_O && $past(CS_SINK_O) && $changed(SDO_O)
    |-> $fell(SCK_O))
    else $error("SDO moved off a falling SCK");
  a_high_phase: assert property (CS_SINK_O && $past(CS_SINK_O) && $fell(SCK_O)
    |-> held_r == SCK_HALF)
    else $error("SCK high phase wrong length");
  // low run spans the whole sleep plus the half period before the first rise
  a_sleep_half: assert property (CS_SINK_O && $rose(SCK_O) && rises_r == 6'h00
    |-> held_r >= 16'(2 * SCK_HALF))
    else $error("sleep shorter than half SCK period");
  a_frame_count: assert property ($fell(CS_SINK_O) |-> rises_r == 6'h20)
    else $error("frame not 32 rising edges");
  a_frame_end: assert property ($fell(CS_SINK_O)
    |-> SDO_O && SCK_O && CS_PU_O && CONV_START_O)
    else $error("bad state after last rising edge");
  a_stay_asleep: assert property (CS_SINK_O && !SCK_O && rises_r == 6'h00 && !CS_BELOW_I
    && !$past(CS_BELOW_I) && !$past(CS_BELOW_I, 2) |=> !SCK_O)
    else $error("woke without chip select below threshold");

  c_frame_done: cover property ($fell(CS_SINK_O));
  c_fifo_full: cover property ($fell(RES_READY_O));
  c_mode_int: cover property ($rose(MODE_INT_O));
endmodule

bind acs_top acs_top_props #(
  .SCK_HALF (SCK_HALF)
) i_acs_top_props (
  .CLK_I        (CLK_I),
  .RESETN_I     (RESETN_I),
  .SCK_O        (SCK_O),
  .SDO_O        (SDO_O),
  .CS_BELOW_I   (CS_BELOW_I),
  .CS_PU_O      (CS_PU_O),
  .CS_SINK_O    (CS_SINK_O),
  .CONV_START_O (CONV_START_O),
  .MODE_INT_O   (MODE_INT_O),
  .RES_READY_O  (RES_READY_O)
);

/* File: sim/acs_ctrl_model.sv */
// far-side controller: latches SDO on rising SCK, packs 32-bit frames
// assumes resolved pin levels; it never drives the device
`timescale 1ns/1ps
module acs_ctrl_model
(
  // resolved pins
  input wire logic sck_i,
  input wire logic sdo_i
);
  logic [31:0] shift_r;
  int          nbit = 0;
  logic [31:0] words[$];

  // done flag lands first, last result bit on the 32nd edge
  always @(posedge sck_i)
  begin
    shift_r = {shift_r[30:0], sdo_i};
    nbit = nbit + 1;
    if (nbit == 32)
    begin
      words.push_back(shift_r);
      nbit = 0;
    end
  end
endmodule

/* File: sim/tb_adc_internal_clock_serial_output.sv */
// bench: drives converter results and the chip-select comparator, checks frames
// assumes the sequencer top, the controller model and the bound checker
`timescale 1ns/1ps
module tb_adc_internal_clock_serial_output
  import acs_pkg::*;
;
  localparam int HALF = 8;
  localparam int PORC = 20;
  logic clk, rstn, ce, sck_pin, sdo_pin, ext_low, below, vld, sck_last, sdo_last;
  logic sck_o, sck_oe, sck_pu, sdo_o, sdo_oe, cs_pu, cs_sink, start, rdy, mode;
  logic [RES_W-1:0]  dat;
  logic [WORD_W-1:0] exp_q[$];
  int                n_fail;
  int                num_checks;

  acs_top #(.POR_CYCLES(PORC), .SCK_HALF(HALF)) i_acs_top (
    .CLK_I(clk), .RESETN_I(rstn), .CE_I(ce), .SCK_I(sck_pin), .SCK_O(sck_o),
    .SCK_OE_O(sck_oe), .SCK_PU_O(sck_pu), .SDO_O(sdo_o), .SDO_OE_O(sdo_oe),
    .CS_BELOW_I(below), .CS_PU_O(cs_pu), .CS_SINK_O(cs_sink), .CONV_START_O(start),
    .RES_VALID_I(vld), .RES_READY_O(rdy), .RES_DATA_I(dat), .MODE_INT_O(mode));
  acs_ctrl_model i_acs_ctrl_model (.sck_i(sck_pin), .sdo_i(sdo_pin));

  // an undriven line without pull shows the inverse of its last driven level
  always @(posedge clk)
  begin
    if (sck_oe || ext_low || sck_pu) sck_last <= sck_pin;
    if (sdo_oe) sdo_last <= sdo_o;
  end
  assign sck_pin = sck_oe ? sck_o : ext_low ? 1'b0 : sck_pu ? 1'b1 : ~sck_last;
  assign sdo_pin = sdo_oe ? sdo_o : ~sdo_last;

  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hold valid until ready is seen; ready is registered so negedge is safe
  task automatic push(input logic [RES_W-1:0] d);
    @(negedge clk);
    dat = d;
    vld = 1'b1;
    while (rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    vld = 1'b0;
    exp_q.push_back({1'b0, d});
  endtask

  task automatic drain(input int n);
    int k = 0;
    while (i_acs_ctrl_model.words.size() < n && k < 20000)
    begin
      @(negedge clk);
      k++;
    end
    repeat (n)
      check(i_acs_ctrl_model.words.pop_front(), exp_q.pop_front());
  endtask

  // reset with SCK strapped low or floating, then a threshold crossing
  task automatic t_por(input logic low);
    ext_low = low;
    below = 1'b0;
    rstn = 1'b0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (PORC / 2) @(negedge clk);
    check(sck_pu, 1'b1);
    check(mode, 1'b0);
    repeat (PORC) @(negedge clk);
    check(mode, !low);
    ext_low = 1'b0;
    below = 1'b1;
    repeat (8) @(negedge clk);
    check(mode, 1'b1);
    check(cs_pu, 1'b1);
    i_acs_ctrl_model.words.delete();
    i_acs_ctrl_model.nbit = 0;
  endtask

  task automatic t_cont;
    below = 1'b1;
    push(31'h2AAA_5555);
    push(31'h7FFF_0001);
    drain(2);
    repeat (HALF + 4) @(negedge clk);
    check({sck_pin, sdo_pin}, 2'h3);
  endtask

  task automatic t_auto;
    below = 1'b0;
    push(31'h1234_5678);
    repeat (4 * HALF) @(negedge clk);
    check({sck_pin, sdo_pin, cs_sink, cs_pu}, 4'h2);
    check(i_acs_ctrl_model.nbit, 0);
    // comparator trips while the clock enable holds all state still
    ce = 1'b0;
    below = 1'b1;
    repeat (4 * HALF) @(negedge clk);
    check({sck_pin, sdo_pin, cs_sink, i_acs_ctrl_model.nbit == 0}, 4'h3);
    ce = 1'b1;
    drain(1);
    repeat (HALF + 4) @(negedge clk);
    check({sck_pin, sdo_pin, cs_sink, cs_pu}, 4'hD);
  endtask

  // fill the buffer while asleep, try one refused word, then drain it all
  task automatic t_fifo;
    below = 1'b0;
    for (int i = 0; i < 9; i++)
      push(RES_W'(32'h4000_0000 >> i));
    @(negedge clk);
    check(rdy, 1'b0);
    dat = 31'h7FFF_FFFF;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    below = 1'b1;
    drain(9);
    repeat (700) @(negedge clk);
    check(i_acs_ctrl_model.words.size(), 0);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // a stuck handshake must still end the run
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    give_verdict;
  end

  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    ext_low = 1'b0;
    below = 1'b0;
    vld = 1'b0;
    dat = '0;
    sck_last = 1'b0;
    sdo_last = 1'b0;
    n_fail = 0;
    num_checks = 0;
    t_por(1'b1);
    t_por(1'b0);
    t_cont;
    t_auto;
    t_fifo;
    give_verdict;
  end
endmodule
